// >>> angular_timer_defs.vh
// constants for the angular phase timer: register map, fields, resets
// Summary of operation
// - module clock divided by resolution plus one; each divider pulse advances period counter
// - active input pulse captures running period counter into latched period value
// - clock divided by latched period plus one advances phase counter, pulses phase clock
// - every phase clock pulse sets the phase event flag
// - phase counter counts up from zero, cleared by input pulse in single-pulse mode
// - multi-pulse: latch and clear period counter except first pulse after missing pulse
// - multi-pulse: first pulse after missing pulse gives period clock, flag, phase reset
// - period counter minus latched period equal to threshold raises missing pulse event
// - threshold is fixed register or half latched period, chosen by adaptive bit
// - adaptive bit one uses half latched period; zero uses fixed threshold
// - single-pulse: missing pulse event drives missing output and sets missed flag
// - multi-pulse: missing event drives output, flag, and marks period timing
`ifndef ANGULAR_TIMER_DEFS_VH
`define ANGULAR_TIMER_DEFS_VH
`define AT_ADR_CONTROL 4'h0
`define AT_ADR_RESOLUTION 4'h1
`define AT_ADR_MISSED 4'h2
`define AT_ADR_PERIOD 4'h3
`define AT_ADR_PHASE 4'h4
`define AT_ADR_FLAGS 4'h5
`define AT_ADR_FLAG_CLR 4'h6
`define AT_ADR_FLAG_EN 4'h7
`define AT_CTL_ENABLE 0
`define AT_CTL_MULTI 1
`define AT_CTL_ADAPTIVE 2
`define AT_CTL_RESET 3'h0
`define AT_FLG_PHASE 0
`define AT_FLG_PERIOD 1
`define AT_FLG_MISSED 2
`define AT_RES_RESET 16'h0000
`define AT_MISS_RESET 16'hFFFF
`endif

// >>> clk_divider.v
// programmable divider: one-cycle pulse every (divisor + 1) advances
`timescale 1ns/1ps
module clk_divider #(
    parameter WIDTH = 16
) (
    input wire clk_i,              // module clock
    input wire rst_i,              // sync reset, high
    input wire restart_i,          // realign count to zero
    input wire advance_i,          // count enable term
    input wire [WIDTH-1:0] div_i,  // divisor minus one
    output reg tick_o              // pulse per wrap
);
    reg [WIDTH-1:0] count;
    always @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            count <= {WIDTH{1'b0}};
            tick_o <= 1'b0;
        end else if (advance_i) begin
            if (count >= div_i) begin
                count <= {WIDTH{1'b0}};
                tick_o <= 1'b1;
            end else begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
                tick_o <= 1'b0;
            end
        end else begin
            tick_o <= 1'b0;
        end
    end
endmodule

// >>> edge_detect.v
// rising edge pulse of the sensor input
`timescale 1ns/1ps
module edge_detect (
    input wire clk_i,   // module clock
    input wire rst_i,   // sync reset, high
    input wire sig_i,   // synchronous level
    output reg rise_o   // one-cycle pulse
);
    reg last;
    always @(posedge clk_i) begin
        if (rst_i) begin
            last <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            last <= sig_i;
            rise_o <= sig_i & ~last;
        end
    end
endmodule

// >>> angular_phase_timer.v
// angular phase timer: period measure, phase subdivision, missing pulse detect
`timescale 1ns/1ps
`include "angular_timer_defs.vh"
module angular_phase_timer #(
    parameter WIDTH = 16
) (
    input wire clk_i,            // module clock 200 MHz
    input wire rst_i,            // sync reset, high
    input wire [3:0] adr_i,      // wishbone word address
    input wire [31:0] dat_i,     // wishbone write data
    output reg [31:0] dat_o,     // wishbone read data
    input wire we_i,             // write enable
    input wire [3:0] sel_i,      // byte selects
    input wire cyc_i,            // cycle
    input wire stb_i,            // strobe
    output reg ack_o,            // acknowledge
    input wire pulse_i,          // sensor pulse, synchronous
    output reg phase_clk_o,      // phase clock pulse
    output reg period_clk_o,     // period clock pulse
    output reg missing_o,        // missing pulse pulse
    output reg irq_o             // level interrupt
);
    ////////////////////////////////////////////////////////////////////
    reg [2:0] timer_control_zero;
    reg [WIDTH-1:0] resolution_value;
    reg [WIDTH-1:0] missed_threshold_value;
    reg [WIDTH-1:0] latched_period_value;
    reg [WIDTH-1:0] period_count;
    reg [WIDTH-1:0] phase_count_value;
    reg [2:0] timer_flag_reg_zero;
    reg [2:0] flag_enable;
    reg after_miss;
    wire enable = timer_control_zero[`AT_CTL_ENABLE];
    wire multi = timer_control_zero[`AT_CTL_MULTI];
    wire adaptive_select_bit = timer_control_zero[`AT_CTL_ADAPTIVE];
    wire period_tick;
    wire phase_tick;
    wire rise;

    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                lane_merge[i*8 +: 8] = sel[i] ? new_val[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    edge_detect u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(pulse_i),
        .rise_o(rise)
    );

    wire pulse = rise & enable;
    // in multi-pulse mode the first pulse after a detected miss keeps the period counter running
    wire skip_latch = multi & after_miss;
    wire latch_now = pulse & ~skip_latch;
    wire phase_reset = pulse & (~multi | after_miss);

    // resolution divider restarts on each latching pulse so periods align
    clk_divider #(.WIDTH(WIDTH)) u_res_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(latch_now),
        .advance_i(enable),
        .div_i(resolution_value),
        .tick_o(period_tick)
    );

    clk_divider #(.WIDTH(WIDTH)) u_phase_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(phase_reset),
        .advance_i(enable),
        .div_i(latched_period_value),
        .tick_o(phase_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // difference taken one advance ahead, so the event lands on the step that reaches it
    // a borrow means the count is still below the latched period: a wrapped
    // negative difference must never match a large threshold such as the reset one
    wire [WIDTH:0] next_diff = {1'b0, period_count} + {{WIDTH{1'b0}}, 1'b1} -
        {1'b0, latched_period_value};
    wire ahead = ~next_diff[WIDTH];
    wire [WIDTH-1:0] threshold = adaptive_select_bit ?
        {1'b0, latched_period_value[WIDTH-1:1]} : missed_threshold_value;
    wire miss_event = enable & period_tick & ~pulse & ahead &
        (next_diff[WIDTH-1:0] == threshold);

    always @(posedge clk_i) begin
        if (rst_i) begin
            period_count <= {WIDTH{1'b0}};
        end else if (latch_now) begin
            period_count <= {WIDTH{1'b0}};
        end else if (period_tick) begin
            period_count <= period_count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            latched_period_value <= {WIDTH{1'b0}};
        end else if (latch_now) begin
            latched_period_value <= period_count;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_count_value <= {WIDTH{1'b0}};
        end else if (phase_reset) begin
            phase_count_value <= {WIDTH{1'b0}};
        end else if (phase_tick) begin
            phase_count_value <= phase_count_value + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // in multi-pulse mode remembers a detected miss until the next accepted pulse consumes it
    always @(posedge clk_i) begin
        if (rst_i) begin
            after_miss <= 1'b0;
        end else if (miss_event && multi) begin
            after_miss <= 1'b1;
        end else if (pulse) begin
            after_miss <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rst_i)
            phase_clk_o <= 1'b0;
        else
            phase_clk_o <= phase_tick & ~phase_reset;
    end

    always @(posedge clk_i) begin
        if (rst_i)
            period_clk_o <= 1'b0;
        else
            period_clk_o <= pulse & skip_latch;
    end

    always @(posedge clk_i) begin
        if (rst_i)
            missing_o <= 1'b0;
        else
            missing_o <= miss_event;
    end

    ////////////////////////////////////////////////////////////////////
    // single-cycle wishbone: ack one cycle after strobe, dropped next cycle
    function hit;
        input [3:0] adr;
        input [3:0] target;
        begin
            hit = (adr == target);
        end
    endfunction

    wire access = cyc_i & stb_i & ~ack_o;
    wire wr = access & we_i;
    wire rd_req = access & ~we_i;
    wire [31:0] wr_data = lane_merge(32'h00000000, dat_i, sel_i);
    // merged words are cut to the register width on purpose
    wire [31:0] ctl_merge = lane_merge({29'h0, timer_control_zero}, dat_i, sel_i);
    wire [31:0] res_merge = lane_merge({{(32-WIDTH){1'b0}}, resolution_value},
        dat_i, sel_i);
    wire [31:0] miss_merge = lane_merge({{(32-WIDTH){1'b0}}, missed_threshold_value},
        dat_i, sel_i);
    wire [31:0] en_merge = lane_merge({29'h0, flag_enable}, dat_i, sel_i);
    wire [2:0] flag_clear = (wr && hit(adr_i, `AT_ADR_FLAG_CLR)) ? wr_data[2:0] : 3'h0;
    wire [2:0] flag_set;
    assign flag_set[`AT_FLG_PHASE] = phase_tick & ~phase_reset;
    assign flag_set[`AT_FLG_PERIOD] = pulse & skip_latch;
    assign flag_set[`AT_FLG_MISSED] = miss_event;

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rst_i)
            timer_control_zero <= `AT_CTL_RESET;
        else if (wr && hit(adr_i, `AT_ADR_CONTROL))
            timer_control_zero <= ctl_merge[2:0];
    end

    always @(posedge clk_i) begin
        if (rst_i)
            resolution_value <= `AT_RES_RESET;
        else if (wr && hit(adr_i, `AT_ADR_RESOLUTION))
            resolution_value <= res_merge[WIDTH-1:0];
    end

    always @(posedge clk_i) begin
        if (rst_i)
            missed_threshold_value <= `AT_MISS_RESET;
        else if (wr && hit(adr_i, `AT_ADR_MISSED))
            missed_threshold_value <= miss_merge[WIDTH-1:0];
    end

    always @(posedge clk_i) begin
        if (rst_i)
            flag_enable <= 3'h0;
        else if (wr && hit(adr_i, `AT_ADR_FLAG_EN))
            flag_enable <= en_merge[2:0];
    end

    // set beats clear in the same cycle, so no event is lost to a late clear
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_flag
            always @(posedge clk_i) begin
                if (rst_i)
                    timer_flag_reg_zero[g] <= 1'b0;
                else if (flag_set[g])
                    timer_flag_reg_zero[g] <= 1'b1;
                else if (flag_clear[g])
                    timer_flag_reg_zero[g] <= 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= access;
    end

    // one cycle behind the flags, which keeps the pin straight off a flip-flop
    always @(posedge clk_i) begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(timer_flag_reg_zero & flag_enable);
    end

    reg [31:0] next_dat;
    always @* begin
        next_dat = 32'h00000000;
        if (rd_req) begin
            case (adr_i)
                `AT_ADR_CONTROL: next_dat = {29'h0, timer_control_zero};
                `AT_ADR_RESOLUTION: next_dat = {{(32-WIDTH){1'b0}}, resolution_value};
                `AT_ADR_MISSED: next_dat = {{(32-WIDTH){1'b0}}, missed_threshold_value};
                `AT_ADR_PERIOD: next_dat = {{(32-WIDTH){1'b0}}, latched_period_value};
                // software read valid if its clock is 3x the phase clock
                `AT_ADR_PHASE: next_dat = {{(32-WIDTH){1'b0}}, phase_count_value};
                `AT_ADR_FLAGS: next_dat = {29'h0, timer_flag_reg_zero};
                `AT_ADR_FLAG_EN: next_dat = {29'h0, flag_enable};
                default: next_dat = 32'h00000000;
            endcase
        end
    end

    // data stands only with ack, zero otherwise
    always @(posedge clk_i) begin
        if (rst_i)
            dat_o <= 32'h00000000;
        else
            dat_o <= next_dat;
    end
endmodule

// >>> angular_timer_checker.sv
// port assertions for the angular phase timer
`timescale 1ns/1ps
module angular_timer_checker #(parameter WIDTH = 16) (
    input logic clk_i, // clock
    input logic rst_i, // reset
    input logic [3:0] adr_i, // address
    input logic [31:0] dat_i, // wdata
    input logic [31:0] dat_o, // rdata
    input logic we_i, // write
    input logic [3:0] sel_i, // lanes
    input logic cyc_i, // cycle
    input logic stb_i, // strobe
    input logic ack_o, // ack
    input logic pulse_i, // sensor
    input logic phase_clk_o, // phase
    input logic period_clk_o, // period
    input logic missing_o, // missing
    input logic irq_o // irq
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // irq may only rise shortly after one of these causes
    wire ev = phase_clk_o | missing_o | period_clk_o | ack_o;
    ////////////////////////////////////////////////////////////
    property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    property p_rd_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("data outside ack");
    property p_per_cause; period_clk_o |-> $past(pulse_i) || $past(pulse_i, 2); endproperty
    a_per_cause: assert property (p_per_cause) else $error("period mark w/o pulse");
    property p_per_once; period_clk_o |=> !period_clk_o; endproperty
    a_per_once: assert property (p_per_once) else $error("period mark held");
    property p_miss_once; missing_o |=> !missing_o; endproperty
    a_miss_once: assert property (p_miss_once) else $error("missing held");
    property p_irq_cause; $rose(irq_o) |-> $past(ev) || $past(ev, 2) || $past(ev, 3); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq w/o cause");
    property p_rst_quiet; disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !missing_o; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy in reset");
endmodule
bind angular_phase_timer angular_timer_checker #(.WIDTH(WIDTH)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pulse_i(pulse_i), .phase_clk_o(phase_clk_o),
    .period_clk_o(period_clk_o), .missing_o(missing_o), .irq_o(irq_o));

// >>> pulse_source.sv
// rotation sensor model: periodic pulse, one may be dropped
`timescale 1ns/1ps
module pulse_source (
    input logic clk_i, // clock
    input logic rst_i, // reset
    input int period_i, // cycles per pulse
    input logic skip_i, // drop next pulse
    output logic pulse_o = 1'b0 // sensor level
);
    int cnt = 0;
    logic drop = 1'b0;
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cnt <= (rst_i || cnt >= period_i - 1) ? 0 : cnt + 1;
        if (cnt == 0) drop <= skip_i;
        // four cycles high, decided once so a drop is never half a pulse
        pulse_o <= !rst_i && cnt < 4 && !(cnt == 0 ? skip_i : drop);
    end
endmodule

// >>> test_angular_phase_timer.sv
// self-checking bench for the angular phase timer
`timescale 1ns/1ps
module test_angular_phase_timer;
    logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, skip = 0, prev = 0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, pulse_i, phase_clk_o, period_clk_o, missing_o, irq_o;
    int miscompares = 0, n_checks = 0, per = 100, res, lpe, thr, cyc = 0, last = 0;
    int ph = 0, ph_at = 0, ph_span = 0, ms = 0, pc = 0, miss_at = 0, ms0, pc0;
    bit [31:0] seed = 32'hE09F75FF;
    angular_phase_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .pulse_i(pulse_i), .phase_clk_o(phase_clk_o),
        .period_clk_o(period_clk_o), .missing_o(missing_o), .irq_o(irq_o));
    pulse_source u_src (.clk_i(clk_i), .rst_i(rst_i), .period_i(per), .skip_i(skip),
        .pulse_o(pulse_i));
    ////////////////////////////////////////////////////////////
    function automatic bit [31:0] xs(bit [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic rng(string nm, int lo, int hi, logic [31:0] g);
        n_checks++;
        if (^g === 1'bx || g < lo || g > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wb(bit w, int a, logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= 4'(a);
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic rd(int a, int lo, int hi);
        wb(0, a, 32'h0);
        rng($sformatf("reg %0d", a), lo, hi, q);
    endtask
    task complete_run;
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        prev <= pulse_i;
        if (phase_clk_o === 1'b1) ph <= ph + 1;
        if (period_clk_o === 1'b1) pc <= pc + 1;
        if (missing_o === 1'b1) begin
            ms <= ms + 1;
            miss_at <= cyc - last;
        end
        if (pulse_i === 1'b1 && prev !== 1'b1) begin
            last <= cyc;
            ph_span <= ph - ph_at;
            ph_at <= ph;
        end
    end
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        complete_run;
    end
    initial begin
        seed = xs(seed);
        res = 1 + seed % 3;
        seed = xs(seed);
        per = 96 + seed % 32;
        lpe = per / (res + 1);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 10; i++)
            if (i != 6) rd(i, i == 2 ? 65535 : 0, i == 2 ? 65535 : 0);
        wb(1, 3, 32'h1234);
        wb(1, 9, 32'h1234);
        rd(3, 0, 0);
        rd(9, 0, 0);
        wb(1, 1, res);
        rd(1, res, res);
        wb(1, 7, 32'h1);
        wb(1, 0, 32'h1);
        repeat (4 * per) @(posedge clk_i);
        rd(3, lpe - 1, lpe + 1);
        rng("phase steps", res, res + 1, ph_span);
        rd(4, 0, res + 1);
        rd(5, 1, 1);
        rng("irq", 1, 1, irq_o);
        wb(1, 0, 32'h0);
        wb(1, 6, 32'h7);
        rd(5, 0, 0);
        rng("irq", 0, 0, irq_o);
        // fixed, adaptive, then multi-pulse; fixed threshold far from the adaptive one
        for (int m = 0; m < 3; m++) begin
            thr = m == 1 ? lpe / 2 : lpe / 4;
            wb(1, 2, lpe / 4);
            wb(1, 7, m == 0 ? 32'h0 : 32'h4);
            wb(1, 0, m == 1 ? 32'h5 : m == 2 ? 32'h3 : 32'h1);
            // let the period stretched by the disabled gap pass before counting
            repeat (2 * per) @(posedge clk_i);
            wb(1, 6, 32'h7);
            ms0 = ms;
            pc0 = pc;
            repeat (3 * per) @(posedge clk_i);
            skip <= 1'b1;
            repeat (per) @(posedge clk_i);
            skip <= 1'b0;
            repeat (2 * per) @(posedge clk_i);
            rng("missing", 1, 1, ms - ms0);
            rng("miss time", (lpe + thr - 2) * (res + 1), (lpe + thr + 2) * (res + 1), miss_at);
            rng("period clk", m / 2, m / 2, pc - pc0);
            rd(5, m == 2 ? 7 : 5, m == 2 ? 7 : 5);
            rng("irq", m != 0, m != 0, irq_o);
        end
        wb(1, 0, 32'h0);
        complete_run;
    end
endmodule
